/* File: core/pvp_pkg.sv */
// Package for the vendor control page of the two-port serial-bus PHY.
// Assumes a single device clock and asynchronous active-high reset.
package pvp_pkg;
	// Register addresses (4-bit); base page is unpaged, speed and soft reset are paged
	localparam logic [3:0] ADDR_ARB_SPEED = 4'h8;
	localparam logic [3:0] ADDR_SOFT_RESET = 4'he;
	localparam logic [3:0] ADDR_BASE_PAGE = 4'h7;
	localparam logic [2:0] PAGE_VENDOR = 3'h7;
	// Field positions
	localparam int NULL_HOLD_BIT = 0;
	localparam int SPEED_LSB = 6;
	localparam int SOFT_RESET_BIT = 0;
	localparam int PAGE_LSB = 5;
	// Speed codes
	localparam logic [1:0] SPD_S100 = 2'h0;
	localparam logic [1:0] SPD_S200 = 2'h1;
	localparam logic [1:0] SPD_S400 = 2'h2;
	localparam logic [1:0] SPD_ILLEGAL = 2'h3;
	localparam logic [2:0] REQ_SPD_S400 = 3'h2;
	// Packet lengths in bits
	localparam logic [15:0] ACK_BITS = 16'h0008;
	localparam logic [3:0] REQ_LEN_SHORT = 4'h7;
	localparam logic [3:0] REQ_LEN_LONG = 4'h8;
	// Reset values
	localparam logic NULL_HOLD_RESET = 1'b0;
	localparam logic [1:0] SPEED_RESET = SPD_S400;
	localparam logic [2:0] PAGE_RESET = 3'h0;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam int RESET_STRETCH = 4;
	localparam logic [2:0] STRETCH_LAST = 3'h4;

	// Register request from the link
	typedef struct packed {
		logic rd;
		logic wr;
		logic [3:0] addr;
		logic [7:0] data;
	} pvp_reg_req_s;

	// Bus request from the link: raw bits and length
	typedef struct packed {
		logic valid;
		logic [3:0] len;
		logic [7:0] bits;
	} pvp_bus_req_s;

	// Received packet summary
	typedef struct packed {
		logic done;
		logic [15:0] nbits;
	} pvp_rx_pkt_s;

	typedef enum logic [1:0] {
		PVP_IDLE,
		PVP_NULL_PFX,
		PVP_NULL_END
	} pvp_tx_e;
endpackage : pvp_pkg

/* File: core/pvp_reset_stretch.sv */
// Stretches a one-cycle software hard reset request into a reset pulse.
// Assumes the request is synchronous to clk_in.
`timescale 1ns/1ps
module pvp_reset_stretch
	import pvp_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic req_in,
	output logic soft_rst_out
);
	typedef struct packed {
		logic [2:0] cnt;
		logic act;
	} pvp_str_s;
	pvp_str_s st_reg;
	pvp_str_s st_next;

	// Count a fixed number of cycles after a request
	always_comb begin
		st_next = st_reg;
		if (req_in) begin
			st_next.act = 1'b1;
			st_next.cnt = 3'h0;
		end else if (st_reg.act) begin
			if (st_reg.cnt == STRETCH_LAST) begin
				st_next.act = 1'b0;
			end else begin
				st_next.cnt = st_reg.cnt + 3'h1;
			end
		end
	end

	// State register under hard reset only
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign soft_rst_out = st_reg.act;
endmodule : pvp_reset_stretch

/* File: core/pvp_vendor_page.sv */
// Vendor-dependent control page of the PHY and the logic it steers.
// Assumes link requests are synchronous to clk_in; straps are static.
`timescale 1ns/1ps
module pvp_vendor_page
	import pvp_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input pvp_reg_req_s reg_req_in,
	input pvp_bus_req_s bus_req_in,
	input pvp_rx_pkt_s rx_pkt_in,
	input wire logic fair_req_in,
	input wire logic prio_req_in,
	input wire logic [2:0] power_class_straps_in,
	input wire logic pwr_class_wr_in,
	input wire logic [2:0] pwr_class_data_in,
	output logic [7:0] rd_data_out,
	output logic rd_valid_out,
	output logic fair_pend_out,
	output logic prio_pend_out,
	output logic [1:0] self_id_rate_field_out,
	output logic [1:0] peer_speed_signal_out,
	output logic [2:0] self_id_pwr_out,
	output logic [2:0] req_speed_out,
	output logic req_ok_out,
	output logic data_prefix_out,
	output logic data_end_out,
	output logic null_packet_request_hold_out,
	output logic hard_reset_out
);
	typedef struct packed {
		logic null_hold;
		logic [1:0] link_speed;
		logic [2:0] page;
		logic [2:0] pwr;
		logic strap_load;
		logic fair;
		logic prio;
		logic [7:0] rdata;
		logic rvalid;
		logic [2:0] rspd;
		logic rok;
		pvp_tx_e tx;
		logic pfx;
		logic dend;
		logic swr_pulse;
		logic [1:0] peer;
	} pvp_state_s;

	pvp_state_s st_reg;
	pvp_state_s st_next;
	logic soft_rst;
	logic int_rst;
	logic vendor_sel;
	logic clear_req;
	logic [2:0] dec_spd;

	// Software reset pulse is stretched and merged into the block reset
	pvp_reset_stretch u_stretch (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.req_in(st_reg.swr_pulse),
		.soft_rst_out(soft_rst)
	);
	assign int_rst = rst_in | soft_rst;

	assign vendor_sel = (st_reg.page == PAGE_VENDOR);

	// Packet clear decision per hold option
	always_comb begin
		if (st_reg.null_hold) begin
			clear_req = rx_pkt_in.done && (rx_pkt_in.nbits > ACK_BITS);
		end else begin
			clear_req = rx_pkt_in.done && (rx_pkt_in.nbits != ACK_BITS);
		end
	end

	// Speed decode: 7-bit form has 2-bit code in low bits, 8-bit form 3-bit
	always_comb begin
		if (bus_req_in.len == REQ_LEN_LONG) begin
			dec_spd = bus_req_in.bits[2:0];
		end else begin
			dec_spd = {1'b0, bus_req_in.bits[1:0]};
		end
	end

	// Next-state logic
	always_comb begin
		st_next = st_reg;
		st_next.rvalid = 1'b0;
		st_next.swr_pulse = 1'b0;
		st_next.strap_load = 1'b0;
		st_next.pfx = 1'b0;
		st_next.dend = 1'b0;
		// Peers always hear S400, whatever the link speed holds
		st_next.peer = SPD_S400;
		// Straps loaded once after reset release
		if (st_reg.strap_load) begin
			st_next.pwr = power_class_straps_in;
		end else if (pwr_class_wr_in) begin
			st_next.pwr = pwr_class_data_in;
		end
		// Register writes
		if (reg_req_in.wr) begin
			if (reg_req_in.addr == ADDR_BASE_PAGE) begin
				st_next.page = reg_req_in.data[PAGE_LSB +: 3];
			end else if (vendor_sel && reg_req_in.addr == ADDR_ARB_SPEED) begin
				st_next.null_hold = reg_req_in.data[NULL_HOLD_BIT];
				st_next.link_speed = reg_req_in.data[SPEED_LSB +: 2];
			end else if (vendor_sel && reg_req_in.addr == ADDR_SOFT_RESET) begin
				st_next.swr_pulse = reg_req_in.data[SOFT_RESET_BIT];
			end
		end
		// Register reads; reserved bits and reset bit read zero
		if (reg_req_in.rd) begin
			st_next.rvalid = 1'b1;
			st_next.rdata = BYTE_ZERO;
			if (reg_req_in.addr == ADDR_BASE_PAGE) begin
				st_next.rdata[PAGE_LSB +: 3] = st_reg.page;
			end else if (vendor_sel && reg_req_in.addr == ADDR_ARB_SPEED) begin
				st_next.rdata[NULL_HOLD_BIT] = st_reg.null_hold;
				st_next.rdata[SPEED_LSB +: 2] = st_reg.link_speed;
			end
		end
		// Pending arbitration requests; a new request wins over a clear
		st_next.fair = fair_req_in | (st_reg.fair & ~clear_req);
		st_next.prio = prio_req_in | (st_reg.prio & ~clear_req);
		// Bus request handling
		if (bus_req_in.valid) begin
			st_next.rspd = dec_spd;
			st_next.rok = (dec_spd <= REQ_SPD_S400);
		end
		// Null packet transmit sequence
		case (st_reg.tx)
			PVP_IDLE: begin
				if (bus_req_in.valid && dec_spd > REQ_SPD_S400) begin
					st_next.tx = PVP_NULL_PFX;
				end
			end
			PVP_NULL_PFX: begin
				st_next.pfx = 1'b1;
				st_next.tx = PVP_NULL_END;
			end
			PVP_NULL_END: begin
				st_next.dend = 1'b1;
				st_next.tx = PVP_IDLE;
			end
			default: begin
				st_next.tx = PVP_IDLE;
			end
		endcase
	end

	// State register under hard or software reset
	always_ff @(posedge clk_in or posedge int_rst) begin
		if (int_rst) begin
			st_reg <= '0;
			st_reg.null_hold <= NULL_HOLD_RESET;
			st_reg.link_speed <= SPEED_RESET;
			st_reg.page <= PAGE_RESET;
			st_reg.strap_load <= 1'b1;
			st_reg.tx <= PVP_IDLE;
			st_reg.peer <= SPD_S400;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from state
	assign rd_data_out = st_reg.rdata;
	assign rd_valid_out = st_reg.rvalid;
	assign fair_pend_out = st_reg.fair;
	assign prio_pend_out = st_reg.prio;
	assign self_id_rate_field_out = st_reg.link_speed;
	assign peer_speed_signal_out = st_reg.peer;
	assign self_id_pwr_out = st_reg.pwr;
	assign req_speed_out = st_reg.rspd;
	assign req_ok_out = st_reg.rok;
	assign data_prefix_out = st_reg.pfx;
	assign data_end_out = st_reg.dend;
	assign null_packet_request_hold_out = st_reg.null_hold;
	assign hard_reset_out = soft_rst;

	// Checks
	a_hold_keeps_req: assert property (@(posedge clk_in) disable iff (int_rst)
		st_reg.null_hold && st_reg.fair && !fair_req_in && rx_pkt_in.done
		&& rx_pkt_in.nbits <= ACK_BITS |=> st_reg.fair)
		else $error("hold set lost fair request");
	a_noh_clears_req: assert property (@(posedge clk_in) disable iff (int_rst)
		!st_reg.null_hold && !fair_req_in && rx_pkt_in.done
		&& rx_pkt_in.nbits != ACK_BITS |=> !st_reg.fair)
		else $error("fair request not cleared");
	a_speed_write: assert property (@(posedge clk_in) disable iff (int_rst)
		reg_req_in.wr && vendor_sel && reg_req_in.addr == ADDR_ARB_SPEED
		|=> self_id_rate_field_out == $past(reg_req_in.data[SPEED_LSB +: 2]))
		else $error("link speed write lost");
	a_peer_s400: assert property (@(posedge clk_in) disable iff (int_rst)
		peer_speed_signal_out == SPD_S400)
		else $error("peer speed not S400");
	a_swr_reads_zero: assert property (@(posedge clk_in) disable iff (int_rst)
		reg_req_in.rd && vendor_sel && reg_req_in.addr == ADDR_SOFT_RESET
		|=> rd_data_out == BYTE_ZERO)
		else $error("soft reset bit read nonzero");
	a_swr_resets: assert property (@(posedge clk_in) disable iff (rst_in)
		reg_req_in.wr && vendor_sel && reg_req_in.addr == ADDR_SOFT_RESET
		&& reg_req_in.data[SOFT_RESET_BIT] |-> ##2 soft_rst)
		else $error("soft reset not performed");
	a_null_packet: assert property (@(posedge clk_in) disable iff (int_rst)
		st_reg.tx == PVP_IDLE && bus_req_in.valid && dec_spd > REQ_SPD_S400
		|=> ##1 data_prefix_out ##1 data_end_out)
		else $error("null packet sequence wrong");
	a_page_gate: assert property (@(posedge clk_in) disable iff (int_rst)
		reg_req_in.wr && !vendor_sel && reg_req_in.addr == ADDR_ARB_SPEED
		|=> $stable(st_reg.link_speed))
		else $error("vendor write without page");

	// Pending request clearing, both kinds, both hold settings
	a_prio_keep: assert property (
		@(posedge clk_in) disable iff (int_rst)
		st_reg.null_hold && st_reg.prio && !prio_req_in && rx_pkt_in.done
		&& rx_pkt_in.nbits <= ACK_BITS |=> st_reg.prio)
		else $error("hold set lost priority request");
	a_prio_clear: assert property (
		@(posedge clk_in) disable iff (int_rst)
		!st_reg.null_hold && !prio_req_in && rx_pkt_in.done
		&& rx_pkt_in.nbits != ACK_BITS |=> !st_reg.prio)
		else $error("priority request not cleared");
	a_long_clear: assert property (
		@(posedge clk_in) disable iff (int_rst)
		st_reg.null_hold && !fair_req_in && rx_pkt_in.done
		&& rx_pkt_in.nbits > ACK_BITS |=> !st_reg.fair)
		else $error("long packet kept fair request");
	a_ack_keeps: assert property (
		@(posedge clk_in) disable iff (int_rst)
		!st_reg.null_hold && st_reg.fair && rx_pkt_in.done
		&& rx_pkt_in.nbits == ACK_BITS |=> st_reg.fair)
		else $error("acknowledge cleared fair request");
	a_req_sets: assert property (
		@(posedge clk_in) disable iff (int_rst)
		fair_req_in |=> fair_pend_out)
		else $error("fair request not pending");

	// Vendor fields change only by their own write
	a_hold_write: assert property (
		@(posedge clk_in) disable iff (int_rst)
		reg_req_in.wr && vendor_sel && reg_req_in.addr == ADDR_ARB_SPEED
		|=> null_packet_request_hold_out == $past(reg_req_in.data[0+NULL_HOLD_BIT]))
		else $error("hold bit write lost");
	a_hold_stable: assert property (
		@(posedge clk_in) disable iff (int_rst)
		!(reg_req_in.wr && vendor_sel && reg_req_in.addr == ADDR_ARB_SPEED)
		|=> $stable(st_reg.null_hold))
		else $error("hold bit changed without write");
	a_speed_stable: assert property (
		@(posedge clk_in) disable iff (int_rst)
		!(reg_req_in.wr && vendor_sel && reg_req_in.addr == ADDR_ARB_SPEED)
		|=> $stable(st_reg.link_speed))
		else $error("link speed changed without write");

	// Read answers of the vendor page
	a_hold_read: assert property (
		@(posedge clk_in) disable iff (int_rst)
		reg_req_in.rd && vendor_sel && reg_req_in.addr == ADDR_ARB_SPEED
		|=> rd_data_out[NULL_HOLD_BIT] == $past(st_reg.null_hold))
		else $error("hold bit read wrong");
	a_speed_read: assert property (
		@(posedge clk_in) disable iff (int_rst)
		reg_req_in.rd && vendor_sel && reg_req_in.addr == ADDR_ARB_SPEED
		|=> rd_data_out[SPEED_LSB +: 2] == $past(st_reg.link_speed))
		else $error("link speed read wrong");
	a_rsvd_read: assert property (
		@(posedge clk_in) disable iff (int_rst)
		reg_req_in.rd && vendor_sel && reg_req_in.addr == ADDR_ARB_SPEED
		|=> rd_data_out[SPEED_LSB - 1 : NULL_HOLD_BIT + 1] == 5'h00)
		else $error("reserved bits read nonzero");
	a_read_valid: assert property (
		@(posedge clk_in) disable iff (int_rst)
		reg_req_in.rd |=> rd_valid_out)
		else $error("read not answered");
	a_unpaged_read: assert property (
		@(posedge clk_in) disable iff (int_rst)
		reg_req_in.rd && !vendor_sel && reg_req_in.addr != ADDR_BASE_PAGE
		|=> rd_data_out == BYTE_ZERO)
		else $error("vendor data seen without page");
	a_unmapped_read: assert property (
		@(posedge clk_in) disable iff (int_rst)
		reg_req_in.rd && reg_req_in.addr != ADDR_ARB_SPEED
		&& reg_req_in.addr != ADDR_BASE_PAGE |=> rd_data_out == BYTE_ZERO)
		else $error("unmapped read nonzero");

	// Bus request decode and null packet framing
	a_short_decode: assert property (
		@(posedge clk_in) disable iff (int_rst)
		bus_req_in.valid && bus_req_in.len == REQ_LEN_SHORT
		|=> req_speed_out == {1'b0, $past(bus_req_in.bits[1:0])})
		else $error("short request decoded wrong");
	a_long_decode: assert property (
		@(posedge clk_in) disable iff (int_rst)
		bus_req_in.valid && bus_req_in.len == REQ_LEN_LONG
		|=> req_speed_out == $past(bus_req_in.bits[2:0]))
		else $error("long request decoded wrong");
	a_prefix_idle: assert property (
		@(posedge clk_in) disable iff (int_rst)
		st_reg.tx == PVP_IDLE |=> !data_prefix_out)
		else $error("prefix without over-speed request");
	a_end_follows: assert property (
		@(posedge clk_in) disable iff (int_rst)
		data_prefix_out |=> data_end_out && !data_prefix_out)
		else $error("data end not right after prefix");

	// Power class from straps, then from register writes
	a_strap_load: assert property (
		@(posedge clk_in) disable iff (int_rst)
		st_reg.strap_load |=> self_id_pwr_out == $past(power_class_straps_in))
		else $error("straps not loaded");
	a_pwr_write: assert property (
		@(posedge clk_in) disable iff (int_rst)
		pwr_class_wr_in && !st_reg.strap_load
		|=> self_id_pwr_out == $past(pwr_class_data_in))
		else $error("power class write lost");
endmodule : pvp_vendor_page

/* File: bench/pvp_link_model.sv */
// Link layer model: register, bus request and packet traffic to the page.
// Assumes the bench calls its tasks; all changes land at falling edges.
`timescale 1ns/1ps
module pvp_link_model
	import pvp_pkg::*;
(
	input wire logic clk_in,
	input wire logic rd_valid_in,
	input wire logic [7:0] rd_data_in,
	output pvp_reg_req_s reg_req_out,
	output pvp_bus_req_s bus_req_out,
	output pvp_rx_pkt_s rx_pkt_out,
	output logic req_out,
	output logic pwr_wr_out,
	output logic [2:0] pwr_data_out
);
	// Quiet lines at time zero
	initial begin
		reg_req_out = '0;
		bus_req_out = '0;
		rx_pkt_out = '0;
		req_out = 1'b0;
		pwr_wr_out = 1'b0;
		pwr_data_out = 3'h0;
	end

	// One-cycle register request; idle lines show inverted leftovers
	task automatic op(input logic r, input logic [3:0] a,
		input logic [7:0] d);
		@(negedge clk_in);
		reg_req_out = {r, ~r, a, d};
		@(negedge clk_in);
		reg_req_out = {2'b00, ~a, ~d};
	endtask : op

	// One-cycle register write: read enable clear, write enable set
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		op(1'b0, a, d);
	endtask : wr

	// Read with a bounded wait for the answer pulse
	task automatic rd(input logic [3:0] a, output logic [7:0] d,
		output logic ok);
		ok = 1'b0;
		d = 8'hxx;
		op(1'b1, a, 8'h00);
		for (int i = 0; i < 3 && !ok; i++) begin
			if (rd_valid_in === 1'b1) begin
				ok = 1'b1;
				d = rd_data_in;
			end else begin
				@(negedge clk_in);
			end
		end
	endtask : rd

	// One-cycle pulses of the other request kinds
	task automatic breq(input logic [3:0] l, input logic [7:0] b);
		@(negedge clk_in);
		bus_req_out = {1'b1, l, b};
		@(negedge clk_in);
		bus_req_out = {1'b0, ~l, ~b};
	endtask : breq

	task automatic pkt(input logic [15:0] n);
		@(negedge clk_in);
		rx_pkt_out = {1'b1, n};
		@(negedge clk_in);
		rx_pkt_out = {1'b0, ~n};
	endtask : pkt

	task automatic req();
		@(negedge clk_in);
		req_out = 1'b1;
		@(negedge clk_in);
		req_out = 1'b0;
	endtask : req

	task automatic pwr(input logic [2:0] d);
		@(negedge clk_in);
		pwr_wr_out = 1'b1;
		pwr_data_out = d;
		@(negedge clk_in);
		pwr_wr_out = 1'b0;
		pwr_data_out = ~d;
	endtask : pwr
endmodule : pvp_link_model

/* File: bench/pvp_vendor_page_bench.sv */
// Self-checking bench for the vendor control page.
// Assumes the link model drives all requests; straps are set by the bench.
`timescale 1ns/1ps
module pvp_vendor_page_bench;
	import pvp_pkg::*;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	pvp_reg_req_s rq;
	pvp_bus_req_s bq;
	pvp_rx_pkt_s rx;
	logic rq1, pwr_wr, rdv, fp, pp, ok, pfx, dend, hold, hrst;
	logic [2:0] pwr_d, pwr, spd;
	logic [2:0] straps = 3'h6;
	logic [1:0] rate, peer;
	logic [7:0] rdd;
	int failures = 0;
	int checks = 0;

	// 40 MHz clock
	initial begin
		forever #12.5 clk_in = ~clk_in;
	end

	pvp_link_model pvp_link_model_i (.clk_in(clk_in), .rd_valid_in(rdv),
		.rd_data_in(rdd), .reg_req_out(rq), .bus_req_out(bq),
		.rx_pkt_out(rx), .req_out(rq1), .pwr_wr_out(pwr_wr),
		.pwr_data_out(pwr_d));
	pvp_vendor_page pvp_vendor_page_i (.clk_in(clk_in), .rst_in(rst_in),
		.reg_req_in(rq), .bus_req_in(bq), .rx_pkt_in(rx),
		.fair_req_in(rq1), .prio_req_in(rq1),
		.power_class_straps_in(straps), .pwr_class_wr_in(pwr_wr),
		.pwr_class_data_in(pwr_d), .rd_data_out(rdd),
		.rd_valid_out(rdv), .fair_pend_out(fp), .prio_pend_out(pp),
		.self_id_rate_field_out(rate), .peer_speed_signal_out(peer),
		.self_id_pwr_out(pwr), .req_speed_out(spd), .req_ok_out(ok),
		.data_prefix_out(pfx), .data_end_out(dend),
		.null_packet_request_hold_out(hold), .hard_reset_out(hrst));

	// Verdict and end of run
	task automatic test_done();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done

	task automatic chk(input logic [7:0] g, input logic [7:0] e,
		input string m);
		checks++;
		if (g !== e) begin
			failures++;
			$display("FAIL %0t %s got %h want %h", $time, m, g, e);
		end
	endtask : chk

	task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic v;
		pvp_link_model_i.rd(a, d, v);
		chk({7'h00, v}, 8'h01, "read answer");
		chk(d, e, "read data");
	endtask : rdchk

	// Bounded wait on prefix or hard reset reaching a level
	task automatic wait_for(input bit h, input logic lvl);
		for (int n = 0; (h ? hrst : pfx) !== lvl; n++) begin
			if (n > 12) begin
				failures++;
				$display("FAIL %0t wait timed out", $time);
				test_done();
			end
			@(negedge clk_in);
		end
	endtask : wait_for

	task automatic pend(input logic [15:0] n, input logic e);
		pvp_link_model_i.pkt(n);
		@(negedge clk_in);
		chk({6'h00, fp, pp}, {6'h00, e, e}, "pending");
	endtask : pend

	// Test sequence
	initial begin
		repeat (10) @(negedge clk_in);
		rst_in = 1'b0;
		repeat (3) @(negedge clk_in);
		chk(8'(rate), 8'h02, "rate reset");
		chk(8'(pwr), 8'h06, "straps");
		chk(8'(hold), 8'h00, "hold reset");
		pvp_link_model_i.wr(ADDR_BASE_PAGE, 8'he0);
		pvp_link_model_i.wr(ADDR_ARB_SPEED, 8'hff);
		rdchk(ADDR_ARB_SPEED, 8'hc1);
		for (int c = 0; c < 3; c++) begin
			pvp_link_model_i.wr(ADDR_ARB_SPEED, {2'(c), 6'h01});
			chk(8'(rate), 8'(c), "rate field");
			chk(8'(peer), 8'h02, "peer speed");
		end
		$display("test registers done");
		// Hold set: only long packets clear; then hold clear: all but acknowledges clear
		pvp_link_model_i.req();
		pend(16'h0008, 1'b1);
		pend(16'h0000, 1'b1);
		pend(16'h0009, 1'b0);
		pvp_link_model_i.wr(ADDR_ARB_SPEED, 8'h80);
		pvp_link_model_i.req();
		pend(16'h0008, 1'b1);
		pend(16'h0005, 1'b0);
		pvp_link_model_i.req();
		pend(16'h0000, 1'b0);
		$display("test pending done");
		// Both request lengths, then over-speed
		pvp_link_model_i.breq(REQ_LEN_SHORT, 8'h01);
		@(negedge clk_in);
		chk({4'h0, ok, spd}, 8'h09, "short request");
		pvp_link_model_i.breq(REQ_LEN_LONG, 8'h02);
		@(negedge clk_in);
		chk({4'h0, ok, spd}, 8'h0a, "long request");
		pvp_link_model_i.breq(REQ_LEN_LONG, 8'h03);
		wait_for(1'b0, 1'b1);
		chk({4'h0, ok, spd}, 8'h03, "fast request");
		@(negedge clk_in);
		chk({6'h00, pfx, dend}, 8'h01, "null end");
		$display("test requests done");
		pvp_link_model_i.pwr(3'h3);
		@(negedge clk_in);
		chk(8'(pwr), 8'h03, "power write");
		rdchk(ADDR_SOFT_RESET, 8'h00);
		// New strap setting must be taken by the soft reset
		straps = 3'h4;
		pvp_link_model_i.wr(ADDR_SOFT_RESET, 8'h01);
		wait_for(1'b1, 1'b1);
		wait_for(1'b1, 1'b0);
		repeat (3) @(negedge clk_in);
		chk({hold, pwr, 2'b00, rate}, 8'h42, "after reset");
		pvp_link_model_i.wr(ADDR_ARB_SPEED, 8'h41);
		pvp_link_model_i.wr(ADDR_BASE_PAGE, 8'he0);
		rdchk(ADDR_ARB_SPEED, 8'h80);
		$display("test soft reset done");
		test_done();
	end
endmodule : pvp_vendor_page_bench
